// *** vsm_client.sv ***
// Model of the client layer that sends slots and management octets
`timescale 1ns/10ps
`default_nettype none
module vsm_client (
  output var logic client_octet_clock,
  output var logic [7:0] slot_octet_in,
  output var logic [1:0] octet_kind_in,
  output var logic octet_valid_in,
  output var logic client_signal_fail_in
);
  // ****************************
  // Octet clock and idle line
  // ****************************
  logic busy = 1'b0; // A slot is being sent
  // Client clock runs free, as an octet clock does
  initial
  begin
    client_octet_clock = 1'b0;
    slot_octet_in = 8'h00;
    octet_kind_in = 2'h0;
    octet_valid_in = 1'b0;
    client_signal_fail_in = 1'b0;
    forever #400 client_octet_clock = ~client_octet_clock;
  end
  // Idle data toggles so a stale octet is never mistaken for data
  always @(negedge client_octet_clock)
    if (!busy) slot_octet_in <= ~slot_octet_in;
  // One octet, changed on the falling edge to be stable at the rise
  task oct(input [7:0] v, input [1:0] k, input ok, input f);
    @(negedge client_octet_clock);
    slot_octet_in = v;
    octet_kind_in = k;
    octet_valid_in = ok;
    client_signal_fail_in = f;
  endtask
  // Slot n: octet j is n+j+1; bad spoils one octet; mg1 nonzero adds mgmt
  task send(input [7:0] n, input [5:0] bad, input f, input [7:0] mg1,
    input [7:0] mg2);
    integer j;
    begin
      busy = 1'b1;
      for (j = 0; j < 53; j++)
      begin
        if (j == 10 && mg1 != 8'h00) oct(mg1, 2'h2, 1'b1, 1'b0);
        if (j == 10 && mg1 != 8'h00) oct(mg2, 2'h3, 1'b1, 1'b0);
        oct(8'(n + j + 1), {1'b0, j == 0}, j != bad || f, j == bad && f);
      end
      oct(8'hAA, 2'h0, 1'b0, 1'b0);
      busy = 1'b0;
    end
  endtask
endmodule // vsm_client
`default_nettype wire

// *** vsm_map.vh ***
// Constants for the VC-4 slot mapper source: layout, codes and timing
`ifndef VSM_MAP_VH
`define VSM_MAP_VH
// ****************************************************************
// Slot layout
// ****************************************************************
`define VSM_SLOT_LAST 6'd52
`define VSM_SLOT_LEN 6'd53
`define VSM_CHECK_IDX 6'd4
`define VSM_PAY_IDX 6'd5
`define VSM_CHECK_MASK 8'h55
`define VSM_VOID_OCTET 8'h00
// ****************************************************************
// Container layout and overhead codes
// ****************************************************************
`define VSM_ROW_LAST 4'd8
`define VSM_COL_LAST 9'd260
`define VSM_ROW_C2 4'd2
`define VSM_ROW_F2 4'd4
`define VSM_ROW_H4 4'd5
`define VSM_ROW_F3 4'd6
`define VSM_C2_LABEL 8'h14
`define VSM_POH_IDLE 8'h00
// ****************************************************************
// Octet kinds on the client side
// ****************************************************************
`define VSM_KIND_DATA 2'h0
`define VSM_KIND_FIRST 2'h1
`define VSM_KIND_MGMT1 2'h2
`define VSM_KIND_MGMT2 2'h3
// ****************************************************************
// Link status codes and timing
// ****************************************************************
`define VSM_LINK_CONNECTED 2'h0
`define VSM_LINK_DOWN 2'h3
`define VSM_LINK_UP 2'h1
`define VSM_LINK_HOB_INCAPABLE 2'h2
`define VSM_RESET_LINK 2'h3
`define VSM_OCTET_DIV 3'd4
`define VSM_SCR_LEN 43
`endif

// *** vsm_scrambler.v ***
// Self-synchronous x^43+1 octet scrambler for the slot payload
`timescale 1ns/10ps
`default_nettype none
`include "vsm_map.vh"

module vsm_scrambler (
  input wire clk_sys,
  input wire reset,
  input wire clk_en,
  input wire advance,
  input wire [7:0] data_in,
  output wire [7:0] data_out
);

  // ****************************************************************
  // Bit chain
  // ****************************************************************
  reg [`VSM_SCR_LEN-1:0] state_q; // Last 43 scrambled bits
  wire [`VSM_SCR_LEN-1:0] chain [0:8]; // State after each bit

  assign chain[0] = state_q;

  // MSB goes first on the line, so it is scrambled first
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_bit
      assign data_out[7-i] = data_in[7-i] ^ chain[i][`VSM_SCR_LEN-1];
      assign chain[i+1] = {chain[i][`VSM_SCR_LEN-2:0], data_out[7-i]};
    end
  endgenerate

  // ****************************************************************
  // State register
  // ****************************************************************
  // Held when not advancing so the sink stays in step
  always @(posedge clk_sys)
  begin
    if (reset)
      state_q <= {`VSM_SCR_LEN{1'b0}};
    else if (clk_en && advance)
      state_q <= chain[8];
  end

endmodule // vsm_scrambler
`default_nettype wire

// *** vsm_slot_mapper.v ***
// Slot mapper source: client slots into VC-4 container with POH bytes
`timescale 1ns/10ps
`default_nettype none
`include "vsm_map.vh"

// What this block does
// - Slots placed row-wise, crossing container ends
// - Scrambler runs only on 48 payload octets
// - Self-synchronous scrambler, polynomial x43 plus one
// - Header check octet XORed with 01010101
// - Slot boundary given once per frame
// - First management in F2, second in F3
// - Add C2, H4; generate fixed frame start
// - H4 bits 1-2 carry link status
// - Link status code values as defined
// - H4 bits 3-8 offset to next boundary
// - Offset always between 0 and 52
// - C2 carries label 0001 0100
// - Drive access point only while activated
// - Invalid or missing input yields void slot
// - Void slot is 53 zero octets
// - Offset tracks slots continuously across frames
module vsm_slot_mapper (
  input wire clk_sys,
  input wire reset,
  input wire clk_en,
  input wire client_octet_clock,
  input wire [7:0] slot_octet_in,
  input wire [1:0] octet_kind_in,
  input wire octet_valid_in,
  input wire client_signal_fail_in,
  input wire [1:0] remote_link_status_in,
  input wire activate_in,
  output wire [7:0] container_data_out,
  output wire container_clock_out,
  output wire container_frame_start_out
);

  // ****************************************************************
  // Input synchroniser
  // ****************************************************************
  reg [15:0] sync1_q; // First stage, read only by second stage
  reg [15:0] sync2_q; // Second stage, safe to use
  reg clk_prev_q; // Previous synced client clock
  wire [15:0] raw_in;
  wire s_clk;
  wire [1:0] s_kind;
  wire s_valid;
  wire s_fail;
  wire [7:0] s_data;
  wire [1:0] s_link;
  wire s_active;
  wire in_edge; // Rising edge of client clock

  assign raw_in = {activate_in, remote_link_status_in, client_octet_clock,
                   octet_kind_in, octet_valid_in, client_signal_fail_in,
                   slot_octet_in};
  assign s_active = sync2_q[15];
  assign s_link = sync2_q[14:13];
  assign s_clk = sync2_q[12];
  assign s_kind = sync2_q[11:10];
  assign s_valid = sync2_q[9];
  assign s_fail = sync2_q[8];
  assign s_data = sync2_q[7:0];
  assign in_edge = s_clk & ~clk_prev_q;

  // Two stages for every pin; data is stable long before the clock
  // edge is seen, so bus skew through the stages is harmless
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      sync1_q <= 16'h0000;
      sync2_q <= 16'h0000;
      clk_prev_q <= 1'b0;
    end
    else if (clk_en)
    begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
      clk_prev_q <= s_clk;
    end
  end

  // ****************************************************************
  // Slot assembly into two banks
  // ****************************************************************
  reg [7:0] slot_mem [0:127]; // Bank in bit 6, octet index below
  reg [1:0] full_q; // Bank holds a complete slot
  reg wr_bank_q; // Bank being filled
  reg rd_bank_q; // Bank being mapped
  reg assembling_q; // Inside a slot being collected
  reg [5:0] in_idx_q; // Next octet index to write
  reg [7:0] mgmt1_in_q; // Latest first management octet
  reg [7:0] mgmt2_in_q; // Latest second management octet
  reg mem_we;
  reg [5:0] mem_widx;
  reg set_full; // Writer completes a slot
  wire clr_full; // Reader finished a slot
  wire in_good;

  assign in_good = in_edge & s_valid & ~s_fail;

  // Write strobe for the slot store
  always @*
  begin
    mem_we = 1'b0;
    mem_widx = in_idx_q;
    set_full = 1'b0;
    if (in_good && s_kind == `VSM_KIND_FIRST && !full_q[wr_bank_q])
    begin
      mem_we = 1'b1;
      mem_widx = 6'd0;
    end
    else if (in_good && s_kind == `VSM_KIND_DATA && assembling_q)
    begin
      mem_we = 1'b1;
      set_full = (in_idx_q == `VSM_SLOT_LAST);
    end
  end

  // Store has no reset; it is only read behind a full flag
  always @(posedge clk_sys)
  begin
    if (clk_en && mem_we)
      slot_mem[{wr_bank_q, mem_widx}] <= s_data;
  end

  // Assembly control; an invalid octet abandons the slot so the
  // reader finds no full bank and sends a void slot instead
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      assembling_q <= 1'b0;
      in_idx_q <= 6'd0;
      wr_bank_q <= 1'b0;
      mgmt1_in_q <= 8'h00;
      mgmt2_in_q <= 8'h00;
    end
    else if (clk_en && in_edge)
    begin
      if (!in_good)
        assembling_q <= 1'b0;
      else
      begin
        case (s_kind)
          `VSM_KIND_FIRST:
          begin
            // A full bank means the output lags; drop this slot
            assembling_q <= ~full_q[wr_bank_q];
            in_idx_q <= 6'd1;
          end
          `VSM_KIND_MGMT1: mgmt1_in_q <= s_data;
          `VSM_KIND_MGMT2: mgmt2_in_q <= s_data;
          default:
          begin
            if (set_full)
            begin
              assembling_q <= 1'b0;
              wr_bank_q <= ~wr_bank_q;
            end
            else if (assembling_q)
              in_idx_q <= in_idx_q + 6'd1;
          end
        endcase
      end
    end
  end

  // Full flags: set wins over clear in the same cycle
  always @(posedge clk_sys)
  begin
    if (reset)
      full_q <= 2'b00;
    else if (clk_en)
    begin
      if (clr_full)
        full_q[rd_bank_q] <= 1'b0;
      if (set_full)
        full_q[wr_bank_q] <= 1'b1;
    end
  end

  // ****************************************************************
  // Container timing
  // ****************************************************************
  reg [2:0] div_q; // Octet rate divider
  reg [3:0] row_q; // Current row 0..8
  reg [8:0] col_q; // Current column, 0 is the POH
  reg [5:0] out_idx_q; // Index of next payload slot octet
  reg use_real_q; // Current output slot is real data
  reg [1:0] link_code_q; // Link status for this frame
  reg [7:0] mgmt1_frm_q; // First management octet for this frame
  reg [7:0] mgmt2_frm_q; // Second management octet for this frame
  wire tick;
  wire is_payload;
  wire frame_top;
  wire real_now;
  wire scr_adv;
  wire [7:0] scr_out;
  wire [7:0] mem_rd;
  wire [5:0] offset;

  assign tick = (div_q == `VSM_OCTET_DIV - 3'd1);
  assign is_payload = (col_q != 9'd0);
  assign frame_top = (row_q == 4'd0) && (col_q == 9'd0);
  assign real_now = (out_idx_q == 6'd0) ? full_q[rd_bank_q] : use_real_q;
  assign mem_rd = slot_mem[{rd_bank_q, out_idx_q}];
  assign clr_full = tick & is_payload & real_now
                    & (out_idx_q == `VSM_SLOT_LAST);
  assign scr_adv = tick & is_payload & real_now
                   & (out_idx_q >= `VSM_PAY_IDX);
  // Octets left in the current slot after H4, 0 at a boundary
  assign offset = (out_idx_q == 6'd0) ? 6'd0
                  : `VSM_SLOT_LEN - out_idx_q;

  vsm_scrambler vsm_scrambler_i (
    .clk_sys(clk_sys),
    .reset(reset),
    .clk_en(clk_en),
    .advance(scr_adv),
    .data_in(mem_rd),
    .data_out(scr_out)
  );

  // Position counters; the slot index runs on across frames
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      div_q <= 3'd0;
      row_q <= 4'd0;
      col_q <= 9'd0;
      out_idx_q <= 6'd0;
      use_real_q <= 1'b0;
      rd_bank_q <= 1'b0;
      link_code_q <= `VSM_RESET_LINK;
      mgmt1_frm_q <= 8'h00;
      mgmt2_frm_q <= 8'h00;
    end
    else if (clk_en)
    begin
      div_q <= tick ? 3'd0 : div_q + 3'd1;
      if (tick)
      begin
        if (frame_top)
        begin
          link_code_q <= s_link;
          mgmt1_frm_q <= mgmt1_in_q;
          mgmt2_frm_q <= mgmt2_in_q;
        end
        if (col_q == `VSM_COL_LAST)
        begin
          col_q <= 9'd0;
          row_q <= (row_q == `VSM_ROW_LAST) ? 4'd0 : row_q + 4'd1;
        end
        else
          col_q <= col_q + 9'd1;
        if (is_payload)
        begin
          use_real_q <= real_now;
          if (out_idx_q == `VSM_SLOT_LAST)
          begin
            out_idx_q <= 6'd0;
            if (real_now)
              rd_bank_q <= ~rd_bank_q;
          end
          else
            out_idx_q <= out_idx_q + 6'd1;
        end
      end
    end
  end

  // ****************************************************************
  // Octet selection and output
  // ****************************************************************
  reg [7:0] next_octet;
  reg [7:0] data_q; // Container octet
  reg clk_q; // One cycle per container octet
  reg fs_q; // Marks the first octet of each container

  // Overhead column by row, otherwise slot octet or void
  always @*
  begin
    next_octet = `VSM_POH_IDLE;
    if (!is_payload)
    begin
      case (row_q)
        `VSM_ROW_C2: next_octet = `VSM_C2_LABEL;
        `VSM_ROW_F2: next_octet = mgmt1_frm_q;
        `VSM_ROW_H4: next_octet = {link_code_q, offset};
        `VSM_ROW_F3: next_octet = mgmt2_frm_q;
        default: next_octet = `VSM_POH_IDLE;
      endcase
    end
    else if (!real_now)
      next_octet = `VSM_VOID_OCTET;
    else if (out_idx_q == `VSM_CHECK_IDX)
      next_octet = mem_rd ^ `VSM_CHECK_MASK;
    else if (out_idx_q >= `VSM_PAY_IDX)
      next_octet = scr_out;
    else
      next_octet = mem_rd;
  end

  // Outputs frozen and quiet while not activated
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      data_q <= 8'h00;
      clk_q <= 1'b0;
      fs_q <= 1'b0;
    end
    else if (clk_en)
    begin
      clk_q <= tick & s_active;
      fs_q <= tick & s_active & frame_top;
      if (tick && s_active)
        data_q <= next_octet;
    end
  end

  assign container_data_out = data_q;
  assign container_clock_out = clk_q;
  assign container_frame_start_out = fs_q;

endmodule // vsm_slot_mapper
`default_nettype wire

// *** vsm_slot_mapper_tb.sv ***
// Testbench for the slot mapper source
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b, m) begin compares++; if ((a) !== (b)) begin \
  fail_count++; $display("mismatch %0t %s", $time, m); end end
module vsm_slot_mapper_tb;
  logic clk_sys, reset, clk_en, activate_in;
  logic [1:0] remote_link_status_in;
  wire client_octet_clock, octet_valid_in, client_signal_fail_in;
  wire [7:0] slot_octet_in, container_data_out;
  wire [1:0] octet_kind_in;
  wire container_clock_out, container_frame_start_out;
  integer fail_count = 0, compares = 0;
  integer pos = -1; // Slot position of next payload octet
  integer nfr = 0; // Frames watched
  logic [7:0] slot [0:52]; // Slot being gathered
  logic [42:0] hist = 43'h0; // Descrambler history
  logic [7:0] q [$]; // Slot numbers due, in order
  logic [1:0] link_e = 2'h3; // Link status due in H4
  logic mok = 1'b0; // Management octets are known
  vsm_slot_mapper vsm_slot_mapper_i (.clk_sys, .reset, .clk_en,
    .client_octet_clock, .slot_octet_in, .octet_kind_in, .octet_valid_in,
    .client_signal_fail_in, .remote_link_status_in, .activate_in,
    .container_data_out, .container_clock_out, .container_frame_start_out);
  vsm_client client_i (.client_octet_clock, .slot_octet_in, .octet_kind_in,
    .octet_valid_in, .client_signal_fail_in);
  // ****************************
  // Clock, waits and verdict
  // ****************************
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task summarize;
    if (fail_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task hang;
    fail_count++;
    summarize;
  endtask
  // Wait for a frame start or an octet strobe, sampled at falling edges
  task wait_on(input fsel);
    integer n;
    begin
      n = 0;
      @(negedge clk_sys);
      while ((fsel ? container_frame_start_out : container_clock_out) !== 1)
      begin
        if (n++ > 9500) hang;
        @(negedge clk_sys);
      end
    end
  endtask
  // Judge a gathered slot: void is all zero, else descramble and compare
  task judge;
    integer j, k;
    logic [7:0] n, o;
    begin
      if (slot[0] == 8'h00)
        for (j = 1; j < 53; j++) `CHK(slot[j], 8'h00, "void")
      else
      begin
        n = q.size() ? q.pop_front() : 8'hFF;
        for (j = 0; j < 53; j++)
        begin
          o = slot[j] ^ (j == 4 ? 8'h55 : 8'h00);
          for (k = 7; k >= 0 && j > 4; k--)
          begin
            o[k] = slot[j][k] ^ hist[42];
            hist = {hist[41:0], slot[j][k]};
          end
          `CHK(o, 8'(n + j + 1), "slot")
        end
      end
    end
  endtask
  // Watch one whole frame of 9 rows by 261 columns
  task frame;
    integer i;
    logic [7:0] b;
    begin
      wait_on(1);
      for (i = 0; i < 2349; i++)
      begin
        if (i > 0) wait_on(0);
        b = container_data_out;
        if (i % 261 != 0 && pos >= 0) slot[pos] = b;
        if (i % 261 != 0 && pos == 52) judge;
        if (i % 261 != 0 && pos >= 0) pos = (pos + 1) % 53;
        if (i == 522) `CHK(b, 8'h14, "c2")
        if (i == 1044 && mok) `CHK(b, 8'hA5, "f2")
        if (i == 1566 && mok) `CHK(b, 8'h3C, "f3")
        if (i == 1305) `CHK(b[7:6], link_e, "link")
        // Octets before the first boundary seen were never captured
        if (i == 1305 && pos < 0) foreach (slot[k]) slot[k] = 8'h00;
        if (i == 1305 && pos < 0) pos = (53 - int'(b[5:0])) % 53;
        if (i == 1305) `CHK(b[5:0], 6'((53 - pos) % 53), "ofs")
        if (i == 1500) remote_link_status_in = 2'(nfr);
      end
      link_e = 2'(nfr);
      nfr++;
    end
  endtask
  // Send 20 slots from n0; slot bad_n gets a spoiled octet bad_j
  task run(input [7:0] n0, input [7:0] bad_n, input [5:0] bad_j, input f);
    integer k;
    for (k = 0; k < 20; k++)
    begin
      if (8'(n0 + k) != bad_n) q.push_back(8'(n0 + k));
      client_i.send(8'(n0 + k), 8'(n0 + k) == bad_n ? bad_j : 6'h3F, f,
        k == 0 ? 8'hA5 : 8'h00, 8'h3C);
    end
  endtask
  // ****************************
  // Scenarios
  // ****************************
  task s_traffic;
    fork run(8'd0, 8'hFF, 6'h3F, 1'b0); join_none
    frame;
    mok = 1'b1;
    frame;
  endtask
  task s_invalid;
    fork run(8'd20, 8'd25, 6'd30, 1'b0); join_none
    frame;
    frame;
  endtask
  task s_fail;
    fork run(8'd40, 8'd45, 6'd52, 1'b1); join_none
    frame;
    frame;
    `CHK(q.size(), 0, "slot lost")
  endtask
  task s_activate;
    integer n, c;
    logic [7:0] d;
    begin
      activate_in = 1'b0;
      repeat (4) @(negedge clk_sys);
      d = container_data_out;
      c = 0;
      for (n = 0; n < 200; n++)
      begin
        @(negedge clk_sys);
        c = c + (container_clock_out | (container_data_out !== d));
      end
      `CHK(c, 0, "muted")
      activate_in = 1'b1;
      wait_on(0);
    end
  endtask
  initial
  begin
    reset = 1'b1;
    clk_en = 1'b1;
    activate_in = 1'b1;
    remote_link_status_in = 2'h3;
    repeat (3) @(negedge clk_sys);
    reset = 1'b0;
    frame;
    s_traffic;
    s_invalid;
    s_fail;
    s_activate;
    summarize;
  end
endmodule // vsm_slot_mapper_tb
bind vsm_slot_mapper vsm_sva vsm_sva_i (.clk_sys, .reset, .activate_in,
  .container_data_out, .container_clock_out, .container_frame_start_out);
`default_nettype wire

// *** vsm_sva.sv ***
// Checker on the container side of the slot mapper
`timescale 1ns/10ps
`default_nettype none
module vsm_sva (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic activate_in,
  input wire logic [7:0] container_data_out,
  input wire logic container_clock_out,
  input wire logic container_frame_start_out
);
  // ****************************
  // Frame phase and H4 history
  // ****************************
  wire ck = container_clock_out; // Octet strobe
  wire fs = container_frame_start_out; // Frame start
  wire [7:0] d = container_data_out; // Octet value
  logic [13:0] cyc_q; // Cycles since frame start
  logic seen_q; // A frame start was seen
  logic pv_q; // Last H4 was seen
  logic [5:0] po_q; // Last H4 offset
  wire h4 = seen_q && cyc_q == 14'd5220; // Row 5 column 0
  // Phase runs on while muted, so it survives deactivation
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      cyc_q <= 14'h0;
      seen_q <= 1'b0;
      pv_q <= 1'b0;
      po_q <= 6'h0;
    end
    else
    begin
      seen_q <= seen_q | fs;
      if (fs) cyc_q <= 14'h1;
      else if (cyc_q == 14'd9395) cyc_q <= 14'h0;
      else cyc_q <= cyc_q + 14'h1;
      if (h4) pv_q <= ck;
      if (h4) po_q <= d[5:0];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence s_mute; !activate_in [*4]; endsequence
  sequence s_h4; h4 && ck; endsequence
  property p_pulse; ck |=> !ck [*3]; endproperty
  property p_fs; fs |-> ck; endproperty
  property p_hold; !ck |-> $stable(d); endproperty
  property p_mute; s_mute |-> !ck; endproperty
  property p_c2; seen_q && ck && cyc_q == 14'd2088 |-> d == 8'h14;
  endproperty
  property p_range; s_h4 |-> d[5:0] <= 6'd52; endproperty
  property p_adv; s_h4 ##0 pv_q |->
    d[5:0] == (({1'b0, po_q} + 7'd45) % 7'd53); endproperty
  property p_frame; fs && seen_q |-> cyc_q == 14'h0; endproperty
  a_pulse: assert property (p_pulse) else $error("strobe gap");
  a_fs: assert property (p_fs) else $error("lone start");
  a_hold: assert property (p_hold) else $error("data moved");
  a_mute: assert property (p_mute) else $error("not muted");
  a_c2: assert property (p_c2) else $error("bad label");
  a_range: assert property (p_range) else $error("offset range");
  a_adv: assert property (p_adv) else $error("offset step");
  a_frame: assert property (p_frame) else $error("frame period");
endmodule // vsm_sva
`default_nettype wire
